// File: src/branch_exec_pkg.sv
package branch_exec_pkg;
	localparam int unsigned pc_w = 21;

	// opcode fields
	localparam logic [3:0] op_bit_clear = 4'h9;
	localparam logic [7:0] op_no_carry  = 8'he3;
	localparam logic [7:0] op_not_neg   = 8'he7;
	localparam logic [7:0] op_no_ovf    = 8'he5;
	localparam logic [7:0] op_neg       = 8'he6;
	localparam logic [4:0] op_jump      = 5'h1a;

	// register offsets
	localparam logic [7:0] reg_ctrl   = 8'h00;
	localparam logic [7:0] reg_instr  = 8'h04;
	localparam logic [7:0] reg_flags  = 8'h08;
	localparam logic [7:0] reg_bank   = 8'h0c;
	localparam logic [7:0] reg_pc     = 8'h10;
	localparam logic [7:0] reg_mem    = 8'h14;
	localparam logic [7:0] reg_status = 8'h18;

	// flag bit positions
	localparam int unsigned flag_c = 0;
	localparam int unsigned flag_v = 3;
	localparam int unsigned flag_n = 4;
	localparam int unsigned flags_w = 5;

	localparam logic [1:0] resp_okay   = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	typedef enum logic [1:0] {
		phase_one,
		phase_two,
		phase_three,
		phase_four
	} phase_t;

	typedef struct packed {
		logic        bit_clear;
		logic        cond_branch;
		logic        jump;
		logic        take;
		logic [7:0]  addr;
		logic [2:0]  bit_pos;
		logic        use_bank;
	} decode_t;
endpackage

// File: src/bit_clear_and_relative_branch_exec.sv
// Overview of operation
// [RULE1] A word with top nibble 1001 clears bit b of register f, other bits kept.
// [RULE2] Access bit a low selects the common bank, a high the bank pointer bank.
// [RULE3] Opcode e3 branches by the 8-bit offset only when carry is clear.
// [RULE4] Opcode e7 branches by the 8-bit offset only when negative is clear.
// [RULE5] Opcode e5 branches by the 8-bit offset only when overflow is clear.
// [RULE6] Top bits 11010 always jump to pc plus 2 plus twice an 11-bit offset.
// [RULE7] Conditional targets are pc plus 2 plus twice the signed 8-bit offset.
// [RULE8] Each is one word; not taken is one cycle, taken adds a no-op cycle.
// [RULE9] None of these instructions alters any arithmetic status flag.
// [RULE10] Opcode e6 branches when negative is set, same target and cost.
// [RULE11] Each cycle runs decode, read, process and write phases in order.
module bit_clear_and_relative_branch_exec #(
	parameter int unsigned mem_depth = 4096
) (
	input  wire logic        aclk,          // core clock
	input  wire logic        aresetn,       // sync reset, active low
	input  wire logic [31:0] s_axi_awaddr,  // write address
	input  wire logic        s_axi_awvalid, // write address valid
	output logic             s_axi_awready, // write address ready
	input  wire logic [31:0] s_axi_wdata,   // write data
	input  wire logic [3:0]  s_axi_wstrb,   // byte strobes
	input  wire logic        s_axi_wvalid,  // write data valid
	output logic             s_axi_wready,  // write data ready
	output logic [1:0]       s_axi_bresp,   // write response
	output logic             s_axi_bvalid,  // write response valid
	input  wire logic        s_axi_bready,  // write response ready
	input  wire logic [31:0] s_axi_araddr,  // read address
	input  wire logic        s_axi_arvalid, // read address valid
	output logic             s_axi_arready, // read address ready
	output logic [31:0]      s_axi_rdata,   // read data
	output logic [1:0]       s_axi_rresp,   // read response
	output logic             s_axi_rvalid,  // read data valid
	input  wire logic        s_axi_rready   // read data ready
);
	localparam int unsigned aw = $clog2(mem_depth);
	localparam int unsigned pw = branch_exec_pkg::pc_w;

	logic [7:0]  mem [mem_depth];
	localparam int unsigned flags_w_l = branch_exec_pkg::flags_w;
	logic [15:0] instr_q;
	logic [flags_w_l-1:0] flags_q;
	logic [3:0]  bank_q;
	logic [pw-1:0] pc_q;
	logic        busy_q;
	logic        nop_q;
	logic        last_taken_q;
	logic [1:0]  last_kind_q;
	branch_exec_pkg::phase_t phase_q;
	branch_exec_pkg::decode_t dec_q;
	logic [7:0]  rdval_q;
	logic [7:0]  wrval_q;
	logic [pw-1:0] target_q;
	logic [11:0] mem_ptr_q;

	// write channel: accept address and data in either order
	logic        aw_held_q;
	logic        w_held_q;
	logic [7:0]  waddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        do_write;
	logic        start;

	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			waddr_q   <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				waddr_q   <= s_axi_awaddr[7:0];
			end else if (do_write) begin
				aw_held_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_q <= 1'b0;
			end
		end
	end

	logic wr_known;
	always_comb begin
		unique case (waddr_q)
			branch_exec_pkg::reg_ctrl, branch_exec_pkg::reg_instr,
			branch_exec_pkg::reg_flags, branch_exec_pkg::reg_bank,
			branch_exec_pkg::reg_pc, branch_exec_pkg::reg_mem:
				wr_known = 1'b1;
			default: wr_known = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= branch_exec_pkg::resp_okay;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_known ? branch_exec_pkg::resp_okay
				: branch_exec_pkg::resp_slverr;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// writes to execution state are ignored while an instruction runs
	logic sw_wr;
	assign sw_wr = do_write && wstrb_q[0] && !busy_q;
	assign start = sw_wr && waddr_q == branch_exec_pkg::reg_ctrl
		&& wdata_q[0];

	logic [7:0]  imm8;
	logic [10:0] imm11;
	logic [7:0]  opc;
	assign imm8  = instr_q[7:0];
	assign imm11 = instr_q[10:0];
	assign opc   = instr_q[15:8];

	// decode in phase one
	branch_exec_pkg::decode_t dec_d;
	always_comb begin
		dec_d          = '0;
		dec_d.addr     = instr_q[7:0];
		dec_d.bit_pos  = instr_q[11:9];
		dec_d.use_bank = instr_q[8];
		// [RULE1] bit clear decode
		if (instr_q[15:12] == branch_exec_pkg::op_bit_clear) begin
			dec_d.bit_clear = 1'b1;
		// [RULE6] unconditional jump
		end else if (instr_q[15:11] == branch_exec_pkg::op_jump) begin
			dec_d.jump = 1'b1;
			dec_d.take = 1'b1;
		// [RULE3] branch if no carry
		end else if (opc == branch_exec_pkg::op_no_carry) begin
			dec_d.cond_branch = 1'b1;
			dec_d.take = !flags_q[branch_exec_pkg::flag_c];
		// [RULE4] branch if not negative
		end else if (opc == branch_exec_pkg::op_not_neg) begin
			dec_d.cond_branch = 1'b1;
			dec_d.take = !flags_q[branch_exec_pkg::flag_n];
		// [RULE5] branch if no overflow
		end else if (opc == branch_exec_pkg::op_no_ovf) begin
			dec_d.cond_branch = 1'b1;
			dec_d.take = !flags_q[branch_exec_pkg::flag_v];
		// [RULE10] branch if negative
		end else if (opc == branch_exec_pkg::op_neg) begin
			dec_d.cond_branch = 1'b1;
			dec_d.take = flags_q[branch_exec_pkg::flag_n];
		end
	end

	// [RULE2] common bank or pointer bank
	logic [11:0] eff_addr;
	assign eff_addr = dec_q.use_bank ? {bank_q, dec_q.addr}
		: {4'h0, dec_q.addr};

	logic [pw-1:0] off_ext;
	assign off_ext = dec_q.jump
		? pw'($signed({imm11, 1'b0}))
		: pw'($signed({imm8, 1'b0}));

	// [RULE11] four phase sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_q <= branch_exec_pkg::phase_one;
			busy_q  <= 1'b0;
			nop_q   <= 1'b0;
		end else if (busy_q) begin
			unique case (phase_q)
				branch_exec_pkg::phase_one:
					phase_q <= branch_exec_pkg::phase_two;
				branch_exec_pkg::phase_two:
					phase_q <= branch_exec_pkg::phase_three;
				branch_exec_pkg::phase_three:
					phase_q <= branch_exec_pkg::phase_four;
				branch_exec_pkg::phase_four: begin
					phase_q <= branch_exec_pkg::phase_one;
					// [RULE8] taken branch adds a no-op cycle
					if (!nop_q && dec_q.take) begin
						nop_q <= 1'b1;
					end else begin
						nop_q  <= 1'b0;
						busy_q <= 1'b0;
					end
				end
			endcase
		end else if (start) begin
			busy_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dec_q    <= '0;
			rdval_q  <= 8'h00;
			wrval_q  <= 8'h00;
			target_q <= '0;
		end else if (busy_q && !nop_q) begin
			unique case (phase_q)
				branch_exec_pkg::phase_one: dec_q <= dec_d;
				branch_exec_pkg::phase_two: rdval_q <= mem[aw'(eff_addr)];
				branch_exec_pkg::phase_three: begin
					// [RULE1] clear only the selected bit
					wrval_q  <= rdval_q & ~(8'h01 << dec_q.bit_pos);
					// [RULE7] pc plus 2 plus twice offset
					target_q <= pc_q + pw'(2) + off_ext;
				end
				branch_exec_pkg::phase_four: ;
			endcase
		end
	end

	logic in_w4;
	assign in_w4 = busy_q && !nop_q
		&& phase_q == branch_exec_pkg::phase_four;

	always_ff @(posedge aclk) begin
		if (in_w4 && dec_q.bit_clear) begin
			mem[aw'(eff_addr)] <= wrval_q;
		end else if (sw_wr && waddr_q == branch_exec_pkg::reg_mem) begin
			mem[aw'(mem_ptr_q)] <= wdata_q[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_q <= '0;
		end else if (in_w4) begin
			if (dec_q.take) begin
				pc_q <= target_q;
			end else begin
				pc_q <= pc_q + pw'(2);
			end
		end else if (sw_wr && waddr_q == branch_exec_pkg::reg_pc) begin
			pc_q <= wdata_q[pw-1:0];
		end
	end

	// [RULE9] flags only change by software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q   <= '0;
			instr_q   <= 16'h0000;
			bank_q    <= 4'h0;
			mem_ptr_q <= 12'h000;
		end else if (sw_wr) begin
			unique case (waddr_q)
				branch_exec_pkg::reg_flags:
					flags_q <= wdata_q[flags_w_l-1:0];
				branch_exec_pkg::reg_instr: instr_q <= wdata_q[15:0];
				branch_exec_pkg::reg_bank: bank_q <= wdata_q[3:0];
				branch_exec_pkg::reg_mem: mem_ptr_q <= wdata_q[27:16];
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_taken_q <= 1'b0;
			last_kind_q  <= 2'h0;
		end else if (in_w4 && !nop_q) begin
			last_taken_q <= dec_q.take;
			last_kind_q  <= {dec_q.jump | dec_q.cond_branch,
				dec_q.bit_clear | dec_q.jump};
		end
	end

	// read channel
	logic [31:0] rd_d;
	logic        rd_ok;
	assign s_axi_arready = !s_axi_rvalid;
	always_comb begin
		rd_d  = 32'h0000_0000;
		rd_ok = 1'b1;
		unique case (s_axi_araddr[7:0])
			branch_exec_pkg::reg_ctrl: rd_d = {31'h0, busy_q};
			branch_exec_pkg::reg_instr: rd_d = {16'h0, instr_q};
			branch_exec_pkg::reg_flags: rd_d = 32'(flags_q);
			branch_exec_pkg::reg_bank: rd_d = {28'h0, bank_q};
			branch_exec_pkg::reg_pc: rd_d = 32'(pc_q);
			branch_exec_pkg::reg_mem:
				rd_d = {4'h0, mem_ptr_q, 8'h0, mem[aw'(mem_ptr_q)]};
			branch_exec_pkg::reg_status:
				rd_d = {28'h0, last_kind_q, last_taken_q, busy_q};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= branch_exec_pkg::resp_okay;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_d;
			s_axi_rresp  <= rd_ok ? branch_exec_pkg::resp_okay
				: branch_exec_pkg::resp_slverr;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	property p_flags_kept;
		@(posedge aclk) disable iff (!aresetn)
		busy_q |=> $stable(flags_q);
	endproperty
	a_flags_kept: assert property (p_flags_kept) // [RULE9]
		else $error("flags changed during execution");

	property p_not_taken_len;
		@(posedge aclk) disable iff (!aresetn)
		$rose(busy_q) && !dec_d.take |-> busy_q [*4] ##1 !busy_q;
	endproperty
	a_not_taken_len: assert property (p_not_taken_len) // [RULE8]
		else $error("not taken did not finish in one cycle");

	property p_taken_len;
		@(posedge aclk) disable iff (!aresetn)
		$rose(busy_q) && dec_d.take |-> busy_q [*8] ##1 !busy_q;
	endproperty
	a_taken_len: assert property (p_taken_len) // [RULE8]
		else $error("taken branch did not take two cycles");

	property p_target;
		@(posedge aclk) disable iff (!aresetn)
		in_w4 && dec_q.take |=> pc_q == $past(target_q);
	endproperty
	a_target: assert property (p_target) // [RULE7]
		else $error("branch target not loaded");

	property p_fall_through;
		@(posedge aclk) disable iff (!aresetn)
		in_w4 && !dec_q.take |=> pc_q == $past(pc_q) + pw'(2);
	endproperty
	a_fall_through: assert property (p_fall_through) // [RULE3]
		else $error("fall through pc wrong");

	property p_clear_bit;
		@(posedge aclk) disable iff (!aresetn)
		busy_q && !nop_q && dec_q.bit_clear
		&& phase_q == branch_exec_pkg::phase_three
		|=> wrval_q == ($past(rdval_q) & ~(8'h01 << dec_q.bit_pos));
	endproperty
	a_clear_bit: assert property (p_clear_bit) // [RULE1]
		else $error("bit clear value wrong");

	property p_phase_order;
		@(posedge aclk) disable iff (!aresetn)
		busy_q && phase_q == branch_exec_pkg::phase_one
		|-> ##3 phase_q == branch_exec_pkg::phase_four;
	endproperty
	a_phase_order: assert property (p_phase_order) // [RULE11]
		else $error("phase sequence broken");

	property p_jump_taken;
		@(posedge aclk) disable iff (!aresetn)
		busy_q && dec_q.jump |-> dec_q.take;
	endproperty
	a_jump_taken: assert property (p_jump_taken) // [RULE6]
		else $error("jump not taken");

	property p_common_bank;
		@(posedge aclk) disable iff (!aresetn)
		!dec_q.use_bank |-> eff_addr[11:8] == 4'h0;
	endproperty
	a_common_bank: assert property (p_common_bank) // [RULE2]
		else $error("common bank not used");

	c_bit_clear: cover property (@(posedge aclk) in_w4 && dec_q.bit_clear);
	c_taken: cover property (@(posedge aclk) in_w4 && dec_q.cond_branch
		&& dec_q.take);
	c_not_taken: cover property (@(posedge aclk) in_w4
		&& dec_q.cond_branch && !dec_q.take);
	c_jump: cover property (@(posedge aclk) in_w4 && dec_q.jump);
endmodule

// File: bench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
`define chk(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end

	logic        aclk;
	logic        aresetn;
	logic [31:0] s_axi_awaddr;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [31:0] s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	int          bad_count = 0;
	int          n_compared = 0;
	int          cycles = 0;

	bit_clear_and_relative_branch_exec dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// a hung handshake ends the run here
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			test_done();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = branch_exec_pkg::resp_okay);
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				`chk(s_axi_bresp, er)
				break;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		input logic [1:0] er = branch_exec_pkg::resp_okay);
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready && !s_axi_rvalid)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				s_axi_rready <= 1'b0;
				`chk(s_axi_rresp, er)
				break;
			end
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		`chk(d, e)
	endtask

	// loads flags, pc and word, starts it and waits for busy to drop
	task automatic run(input logic [15:0] ins, input logic [4:0] fl,
		input logic [20:0] pc0, input logic [20:0] epc,
		input logic tk, input logic [1:0] kind);
		logic [31:0] d;
		wr(branch_exec_pkg::reg_flags, {27'h0, fl});
		wr(branch_exec_pkg::reg_pc, {11'h0, pc0});
		wr(branch_exec_pkg::reg_instr, {16'h0, ins});
		wr(branch_exec_pkg::reg_ctrl, 32'h1);
		for (int t = 0; t < 40; t++) begin
			rd(branch_exec_pkg::reg_status, d);
			if (d[0] === 1'b0)
				break;
		end
		`chk(d[3:0], {kind, tk, 1'b0})
		rchk(branch_exec_pkg::reg_pc, {11'h0, epc});
		rchk(branch_exec_pkg::reg_flags, {27'h0, fl});
	endtask

	task automatic t_reset();
		logic [31:0] d;
		// the data byte behind the memory port is not reset, its pointer is
		for (int i = 0; i < 7; i++) begin
			rd(8'(i * 4), d);
			`chk(d & (i == 5 ? 32'hffff_ff00 : 32'hffff_ffff), 32'h0)
		end
		rd(8'h1c, d, branch_exec_pkg::resp_slverr);
		wr(8'h20, 32'h1, branch_exec_pkg::resp_slverr);
	endtask

	// a data write lands at the old pointer while the pointer moves on
	task automatic t_bit_clear();
		wr(branch_exec_pkg::reg_bank, 32'h3);
		wr(branch_exec_pkg::reg_mem, 32'h0325_0000);
		wr(branch_exec_pkg::reg_mem, 32'h0025_00ff);
		wr(branch_exec_pkg::reg_mem, 32'h0025_00c7);
		run(16'h9e25, 5'h19, 21'h100, 21'h102, 1'b0, 2'b01);
		rchk(branch_exec_pkg::reg_mem, 32'h0025_0047);
		wr(branch_exec_pkg::reg_mem, 32'h0325_0047);
		rchk(branch_exec_pkg::reg_mem, 32'h0325_00ff);
		run(16'h9125, 5'h06, 21'h102, 21'h104, 1'b0, 2'b01);
		rchk(branch_exec_pkg::reg_mem, 32'h0325_00fe);
	endtask

	// other flags are set opposite so only the tested one can decide
	task automatic t_cond();
		logic [7:0] ops[4] = '{branch_exec_pkg::op_no_carry,
			branch_exec_pkg::op_not_neg, branch_exec_pkg::op_no_ovf,
			branch_exec_pkg::op_neg};
		int bits[4] = '{0, 4, 3, 4};
		logic want[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
		logic [4:0] fl;
		logic [7:0] off;
		logic tk;
		logic [20:0] pc0 = 21'h1000;
		for (int i = 0; i < 4; i++) begin
			for (int v = 0; v < 2; v++) begin
				fl = v[0] ? 5'h1 << bits[i] : ~(5'h1 << bits[i]);
				off = v[0] ? 8'h7f : 8'h80;
				tk = (v[0] == want[i]);
				run({ops[i], off}, fl, pc0, tk ? pc0 + 21'd2 +
					{{12{off[7]}}, off, 1'b0} : pc0 + 21'd2,
					tk, 2'b10);
			end
		end
	endtask

	task automatic t_jump();
		logic [15:0] w;
		w = {branch_exec_pkg::op_jump, 11'h400};
		run(w, 5'h1f, 21'h1000, 21'h802, 1'b1, 2'b11);
		run(w, 5'h0a, 21'h0, 21'h1ff802, 1'b1, 2'b11);
		w = {branch_exec_pkg::op_jump, 11'h3ff};
		run(w, 5'h00, 21'h1000, 21'h1800, 1'b1, 2'b11);
		run(16'hffff, 5'h1f, 21'h20, 21'h22, 1'b0, 2'b00);
	endtask

	// refused writes: low byte lane off, or while an instruction runs
	task automatic t_refused();
		s_axi_wstrb <= 4'he;
		wr(branch_exec_pkg::reg_bank, 32'h5);
		s_axi_wstrb <= 4'hf;
		rchk(branch_exec_pkg::reg_bank, 32'h3);
		wr(branch_exec_pkg::reg_instr,
			{16'h0, branch_exec_pkg::op_jump, 11'h004});
		wr(branch_exec_pkg::reg_pc, 32'h40);
		wr(branch_exec_pkg::reg_ctrl, 32'h1);
		wr(branch_exec_pkg::reg_pc, 32'h0);
		repeat (10) @(posedge aclk);
		rchk(branch_exec_pkg::reg_pc, 32'h4a);
	endtask

	initial begin
		aresetn = 1'b0;
		s_axi_awaddr = 32'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 32'h0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_bit_clear();
		t_cond();
		t_jump();
		t_refused();
		test_done();
	end
endmodule
